// >>> ee_pkg.sv
package ee_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ     = 125000;
  localparam int SCL_KHZ     = 400;
  // Quarter of a serial clock period, rounded up so the bus is never fast
  localparam int QTR_CYC     = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  // internal_write_time, longest, in ms
  localparam int WR_TIME_MS  = 10;
  localparam int WR_TIME_CYC = WR_TIME_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Protocol constants
  // ----------------------------------------------------------------
  localparam int         REC_BITS   = 9;
  localparam int         PAGE_BYTES = 64;
  localparam int         ADDR_W     = 15;
  localparam logic [4:0] DEV_TYPE   = 5'h14;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [6:0] LEN_ONE    = 7'h01;
  localparam logic [6:0] PAGE_LEN   = 7'(PAGE_BYTES);
  localparam logic [3:0] REC_LAST   = 4'(REC_BITS - 1);

  // Quarter phases of one bit time
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE  = 2'h1;
  localparam logic [1:0] PH_HIGH  = 2'h2;
  localparam logic [1:0] PH_FALL  = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BC_START,
    BC_STOP,
    BC_WRITE,
    BC_READ
  } ee_bcmd_t;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_READ_CUR,
    OP_READ_RAND,
    OP_RECOVER
  } ee_op_t;

  typedef struct packed {
    ee_op_t      op;
    logic        address_strap_high;
    logic        address_strap_low;
    logic [15:0] addr;
    logic [6:0]  len;
  } ee_req_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } ee_drv_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } ee_lvl_t;

endpackage

// >>> ee_sync.sv
`timescale 1ns/1ps

module ee_sync #(
  parameter int W = 2
) (
  input  logic         clock,
  input  logic         rst,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } ee_sync_st_t;

  ee_sync_st_t s_reg;
  ee_sync_st_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = d;
    s_next.safe = s_reg.meta;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.safe;

endmodule

// >>> ee_bit.sv
`timescale 1ns/1ps

module ee_bit #(
  parameter int QTR = ee_pkg::QTR_CYC
) (
  input  logic             clock,
  input  logic             rst,
  input  logic             cmd_valid,
  input  ee_pkg::ee_bcmd_t cmd,
  input  logic             tx_bit,
  input  ee_pkg::ee_lvl_t  lvl,
  output logic             ready,
  output logic             done,
  output logic             rx_bit,
  output ee_pkg::ee_drv_t  drv
);

  localparam int             CW       = $clog2(QTR + 1);
  localparam logic [CW-1:0]  CNT_LAST = CW'(QTR - 1);

  typedef struct packed {
    logic             busy;
    logic [1:0]       ph;
    logic [CW-1:0]    cnt;
    ee_pkg::ee_bcmd_t cmd;
    logic             txb;
    logic             rxb;
    logic             done;
    ee_pkg::ee_drv_t  drv;
  } ee_bit_st_t;

  ee_bit_st_t s_reg;
  ee_bit_st_t s_next;

  // ----------------------------------------------------------------
  // Pin drive for each quarter of each bit command
  // ----------------------------------------------------------------
  function automatic ee_pkg::ee_drv_t drv_of(ee_pkg::ee_bcmd_t c,
                                             logic [1:0] ph,
                                             logic tx,
                                             logic scl_prev);
    ee_pkg::ee_drv_t d;
    d.scl_oe = (ph == ee_pkg::PH_SETUP) || (ph == ee_pkg::PH_FALL);
    d.sda_oe = 1'b0;
    unique case (c)
      ee_pkg::BC_START: begin
        // SDA falls while SCL is high
        d.scl_oe = (ph == ee_pkg::PH_SETUP) ? scl_prev
                                             : (ph == ee_pkg::PH_FALL);
        d.sda_oe = (ph == ee_pkg::PH_HIGH) || (ph == ee_pkg::PH_FALL);
      end
      ee_pkg::BC_STOP: begin
        // SDA rises while SCL is high
        d.scl_oe = (ph == ee_pkg::PH_SETUP);
        d.sda_oe = (ph == ee_pkg::PH_SETUP) || (ph == ee_pkg::PH_RISE);
      end
      ee_pkg::BC_WRITE: begin
        d.sda_oe = ~tx;
      end
      ee_pkg::BC_READ: begin
        d.sda_oe = 1'b0;
      end
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Bit sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.busy) begin
      if (cmd_valid) begin
        s_next.busy = 1'b1;
        s_next.cmd  = cmd;
        s_next.txb  = tx_bit;
        s_next.ph   = ee_pkg::PH_SETUP;
        s_next.cnt  = '0;
      end
    end else if (s_reg.cnt != CNT_LAST) begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end else if (!(s_reg.ph == ee_pkg::PH_RISE && !lvl.scl)) begin
      // A slave holding SCL low stretches the rise phase
      s_next.cnt = '0;
      s_next.ph  = s_reg.ph + 2'(1);
      if (s_reg.ph == ee_pkg::PH_HIGH) begin
        s_next.rxb = lvl.sda;
      end
      if (s_reg.ph == ee_pkg::PH_FALL) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
    end
    if (s_next.busy) begin
      s_next.drv = drv_of(s_next.cmd, s_next.ph, s_next.txb,
                          s_reg.drv.scl_oe);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ready  = !s_reg.busy;
  assign done   = s_reg.done;
  assign rx_bit = s_reg.rxb;
  assign drv    = s_reg.drv;

endmodule

// >>> ee_host.sv
`timescale 1ns/1ps

// Functional notes
// - SDA changes only while SCL low
// - SDA fall with SCL high starts command
// - SDA rise with SCL high is stop
// - Recover: up to nine clocks, then start
// - Device word carries fixed type prefix
// - Byte write: two address bytes, data, stop
// - Page write: up to 64 data bytes
// - Header acknowledged only after write ends
// - Current read: one byte, no ack, stop
// - Random read: dummy write, repeated start
// - Master ack continues sequential read
module ee_host #(
  parameter int         QTR_CYC  = ee_pkg::QTR_CYC,
  parameter int         WR_CYC   = ee_pkg::WR_TIME_CYC,
  parameter int         ADDR_W   = ee_pkg::ADDR_W,
  parameter logic [4:0] DEV_TYPE = ee_pkg::DEV_TYPE
) (
  input  logic            clock,
  input  logic            rst,
  input  logic            req_valid,
  input  ee_pkg::ee_req_t req,
  output logic            req_ready,
  input  logic [7:0]      wr_data,
  output logic            wr_take,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done,
  output logic            error,
  input  logic            protect_level,
  output logic            write_inhibit,
  input  logic            scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  logic            sda_i,
  output logic            sda_o,
  output logic            sda_oe
);

  localparam int          WCW       = $clog2(WR_CYC + 1);
  localparam logic [WCW-1:0] WR_LIM = WCW'(WR_CYC);
  localparam logic [15:0] ADDR_MASK = 16'((32'h1 << ADDR_W) - 32'h1);

  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_TXB,
    S_TXACK,
    S_RXB,
    S_RXACK,
    S_STOP,
    S_REC
  } ee_host_state_t;

  typedef enum logic [1:0] {
    N_DEV,
    N_AH,
    N_AL,
    N_DATA
  } ee_host_next_t;

  typedef struct packed {
    ee_host_state_t st;
    ee_host_next_t  nx;
    logic           iss;
    ee_pkg::ee_op_t op;
    logic [1:0]     strap;
    logic [15:0]    addr;
    logic [6:0]     len;
    logic [7:0]     sh;
    logic [2:0]     bitn;
    logic           rnw;
    logic           pend;
    logic           poll;
    logic           rec;
    logic           err;
    logic [3:0]     rcnt;
    logic [WCW-1:0] wcnt;
    logic           rdy;
    logic           wtake;
    logic           rdv;
    logic [7:0]     rdd;
    logic           done;
    logic           errout;
    logic           wi;
    logic           lo;
  } ee_host_st_t;

  ee_host_st_t      s_reg;
  ee_host_st_t      s_next;
  ee_pkg::ee_lvl_t  lvl;
  ee_pkg::ee_drv_t  drv;
  ee_pkg::ee_bcmd_t bcmd;
  logic             bvalid;
  logic             btx;
  logic             b_ready;
  logic             b_done;
  logic             b_rx;
  logic [6:0]       len_in;

  // ----------------------------------------------------------------
  // Device address word
  // ----------------------------------------------------------------
  function automatic logic [7:0] dev_byte(logic [1:0] strap, logic rnw);
    return {DEV_TYPE, strap, rnw};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and bit sequencer
  // ----------------------------------------------------------------
  ee_sync #(
    .W (2)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({scl_i, sda_i}),
    .q     (lvl)
  );

  ee_bit #(
    .QTR (QTR_CYC)
  ) u_bit (
    .clock     (clock),
    .rst       (rst),
    .cmd_valid (bvalid),
    .cmd       (bcmd),
    .tx_bit    (btx),
    .lvl       (lvl),
    .ready     (b_ready),
    .done      (b_done),
    .rx_bit    (b_rx),
    .drv       (drv)
  );

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.wtake = 1'b0;
    s_next.rdv   = 1'b0;
    s_next.done  = 1'b0;
    s_next.wi    = protect_level;
    bcmd         = ee_pkg::BC_READ;
    btx          = 1'b1;
    bvalid       = !s_reg.iss && (s_reg.st != S_IDLE);
    len_in       = (req.len == '0) ? ee_pkg::LEN_ONE : req.len;
    if (req.op == ee_pkg::OP_WRITE && len_in > ee_pkg::PAGE_LEN) begin
      len_in = ee_pkg::PAGE_LEN;
    end
    if (bvalid && b_ready) begin
      s_next.iss = 1'b1;
    end
    if (b_done) begin
      s_next.iss = 1'b0;
    end
    if (s_reg.poll && s_reg.wcnt != WR_LIM) begin
      s_next.wcnt = s_reg.wcnt + WCW'(1);
    end
    unique case (s_reg.st)
      S_IDLE: begin
        if (req_valid) begin
          s_next.op    = req.op;
          s_next.strap = {req.address_strap_high,
                          req.address_strap_low};
          s_next.addr  = req.addr & ADDR_MASK;
          s_next.len   = len_in;
          s_next.err   = 1'b0;
          s_next.pend  = 1'b0;
          s_next.poll  = 1'b0;
          s_next.rcnt  = '0;
          s_next.wcnt  = '0;
          s_next.nx    = N_DEV;
          s_next.rec   = (req.op == ee_pkg::OP_RECOVER);
          s_next.rnw   = (req.op == ee_pkg::OP_READ_CUR);
          s_next.sh    = dev_byte(s_next.strap, s_next.rnw);
          s_next.st    = s_next.rec ? S_REC : S_START;
        end
      end
      S_START: begin
        bcmd = ee_pkg::BC_START;
        if (b_done) begin
          s_next.bitn = '0;
          s_next.st   = s_reg.rec ? S_STOP : S_TXB;
        end
      end
      S_TXB: begin
        bcmd = ee_pkg::BC_WRITE;
        btx  = s_reg.sh[7];
        if (b_done) begin
          s_next.sh   = {s_reg.sh[6:0], 1'b0};
          s_next.bitn = s_reg.bitn + 3'(1);
          if (s_reg.bitn == ee_pkg::LAST_BIT) begin
            s_next.st = S_TXACK;
          end
        end
      end
      S_TXACK: begin
        bcmd = ee_pkg::BC_READ;
        if (b_done) begin
          s_next.bitn = '0;
          if (b_rx) begin
            // No acknowledge: busy device, absent device or refusal
            s_next.st = S_STOP;
            if (!(s_reg.nx == N_DEV && s_reg.poll
                  && s_reg.wcnt < WR_LIM)) begin
              s_next.err  = 1'b1;
              s_next.poll = 1'b0;
            end
          end else begin
            unique case (s_reg.nx)
              N_DEV: begin
                if (s_reg.poll) begin
                  s_next.poll = 1'b0;
                  s_next.st   = S_STOP;
                end else if (s_reg.rnw) begin
                  s_next.st = S_RXB;
                end else begin
                  s_next.sh = s_reg.addr[15:8];
                  s_next.nx = N_AH;
                  s_next.st = S_TXB;
                end
              end
              N_AH: begin
                s_next.sh = s_reg.addr[7:0];
                s_next.nx = N_AL;
                s_next.st = S_TXB;
              end
              N_AL: begin
                if (s_reg.op == ee_pkg::OP_READ_RAND) begin
                  s_next.rnw = 1'b1;
                  s_next.sh  = dev_byte(s_reg.strap, 1'b1);
                  s_next.nx  = N_DEV;
                  s_next.st  = S_START;
                end else begin
                  s_next.sh    = wr_data;
                  s_next.wtake = 1'b1;
                  s_next.nx    = N_DATA;
                  s_next.st    = S_TXB;
                end
              end
              N_DATA: begin
                s_next.len = s_reg.len - 7'(1);
                if (s_reg.len == ee_pkg::LEN_ONE) begin
                  s_next.pend = 1'b1;
                  s_next.st   = S_STOP;
                end else begin
                  s_next.sh    = wr_data;
                  s_next.wtake = 1'b1;
                  s_next.st    = S_TXB;
                end
              end
            endcase
          end
        end
      end
      S_RXB: begin
        bcmd = ee_pkg::BC_READ;
        if (b_done) begin
          s_next.sh   = {s_reg.sh[6:0], b_rx};
          s_next.bitn = s_reg.bitn + 3'(1);
          if (s_reg.bitn == ee_pkg::LAST_BIT) begin
            s_next.rdd = {s_reg.sh[6:0], b_rx};
            s_next.rdv = 1'b1;
            s_next.st  = S_RXACK;
          end
        end
      end
      S_RXACK: begin
        bcmd = ee_pkg::BC_WRITE;
        btx  = (s_reg.len == ee_pkg::LEN_ONE);
        if (b_done) begin
          s_next.len  = s_reg.len - 7'(1);
          s_next.bitn = '0;
          s_next.st   = (s_reg.len == ee_pkg::LEN_ONE) ? S_STOP : S_RXB;
        end
      end
      S_STOP: begin
        bcmd = ee_pkg::BC_STOP;
        if (b_done) begin
          if (s_reg.pend || s_reg.poll) begin
            // Acknowledge polling while the internal write runs
            if (s_reg.pend) begin
              s_next.wcnt = '0;
            end
            s_next.pend = 1'b0;
            s_next.poll = 1'b1;
            s_next.rnw  = 1'b0;
            s_next.sh   = dev_byte(s_reg.strap, 1'b0);
            s_next.nx   = N_DEV;
            s_next.st   = S_START;
          end else begin
            s_next.rec    = 1'b0;
            s_next.done   = 1'b1;
            s_next.errout = s_reg.err;
            s_next.st     = S_IDLE;
          end
        end
      end
      S_REC: begin
        bcmd = ee_pkg::BC_READ;
        if (b_done) begin
          s_next.rcnt = s_reg.rcnt + 4'(1);
          if (b_rx) begin
            s_next.st = S_START;
          end else if (s_reg.rcnt == ee_pkg::REC_LAST) begin
            s_next.err = 1'b1;
            s_next.st  = S_STOP;
          end
        end
      end
    endcase
    s_next.rdy = (s_next.st == S_IDLE);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg     <= '0;
      s_reg.rdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready     = s_reg.rdy;
  assign wr_take       = s_reg.wtake;
  assign rd_data       = s_reg.rdd;
  assign rd_valid      = s_reg.rdv;
  assign done          = s_reg.done;
  assign error         = s_reg.errout;
  assign write_inhibit = s_reg.wi;
  assign scl_o         = s_reg.lo;
  assign sda_o         = s_reg.lo;
  assign scl_oe        = drv.scl_oe;
  assign sda_oe        = drv.sda_oe;

endmodule

// >>> ee_host_monitor.sv
`timescale 1ns/1ps

module ee_host_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic wr_take,
  input wire logic rd_valid,
  input wire logic done,
  input wire logic protect_level,
  input wire logic write_inhibit,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Checks on the host side of the two-wire bus
  // ----------------------------------------------------------------
  a_ready_at_done: assert property (done |-> req_ready)
    else $error("ready not back with done");
  a_taken_busy: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready stayed high after a request");
  a_inhibit_follow: assert property ($rose(protect_level) |=> write_inhibit)
    else $error("write inhibit did not follow");
  a_data_setup: assert property ($changed(sda_oe) |-> $stable(scl_oe))
    else $error("data moved with the clock edge");
  a_open_drain: assert property (req_ready |-> !scl_oe && !sda_oe
                                 && !scl_o && !sda_o)
    else $error("bus not released while idle");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_stop_idle: assert property (done |-> !scl_oe && !sda_oe)
    else $error("bus not released at done");
  a_take_gap: assert property (wr_take |=> (!wr_take) [*8])
    else $error("data bytes too close");
  a_read_gap: assert property (rd_valid |=> (!rd_valid) [*8])
    else $error("read bytes too close");
endmodule

// >>> ee_eeprom_model.sv
`timescale 1ns/1ps

module ee_eeprom_model #(
  parameter logic [4:0] DEV_TYPE = 5'h14,
  parameter logic [1:0] STRAP    = 2'h1,
  parameter int         BUSY_NS  = 5000
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic write_inhibit,
  output logic      sda_oe
);
  logic [7:0]  mem [0:32767];
  logic [7:0]  sh;
  logic [14:0] ptr;
  logic        busy;
  logic        wrote;
  int          st;
  int          bitn;

  // ----------------------------------------------------------------
  // Byte handling at the ninth clock
  // ----------------------------------------------------------------
  task automatic take_byte;
    sda_oe = 1'b1;
    case (st)
      1: begin
        if (sh[7:3] != DEV_TYPE || sh[2:1] != STRAP || busy) begin
          sda_oe = 1'b0;
          st = 0;
        end else begin
          st = sh[0] ? 6 : 2;
        end
      end
      2: begin
        ptr[14:8] = sh[6:0];
        st = 3;
      end
      3: begin
        ptr[7:0] = sh;
        st = 4;
      end
      default: begin
        if (!write_inhibit) begin
          mem[ptr] = sh;
          wrote = 1'b1;
        end
        ptr[5:0] = ptr[5:0] + 6'h01;
      end
    endcase
  endtask

  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    ptr = 15'h0000;
    busy = 1'b0;
    wrote = 1'b0;
    st = 0;
    bitn = 0;
    sda_oe = 1'b0;
  end

  always @(negedge sda) if (scl) begin
    st = 1;
    bitn = 0;
  end

  always @(posedge sda) if (scl) begin
    st = 0;
    if (wrote) begin
      wrote = 1'b0;
      busy = 1'b1;
      busy <= #(BUSY_NS) 1'b0;
    end
  end

  always @(posedge scl) begin
    if (st != 0 && bitn < 8) begin
      if (st < 5) sh = {sh[6:0], sda};
      bitn++;
    end else if (bitn == 8) begin
      bitn = 0;
      if (st == 5 && sda) st = 0;
      else if (st >= 5) begin
        st = 5;
        sh = mem[ptr];
        ptr = ptr + 15'h0001;
      end
    end
  end

  always @(negedge scl) begin
    sda_oe = 1'b0;
    if (st == 5 && bitn < 8) sda_oe = !sh[7 - bitn];
    else if (bitn == 8 && st != 0 && st < 5) take_byte();
  end
endmodule

// >>> ee_host_test.sv
`timescale 1ns/1ps

module ee_host_test;
  logic            clock;
  logic            rst;
  logic            req_valid;
  ee_pkg::ee_req_t req;
  logic [7:0]      wr_data;
  logic [7:0]      rd_data;
  logic            req_ready;
  logic            wr_take;
  logic            rd_valid;
  logic            done;
  logic            error;
  logic            protect_level;
  logic            write_inhibit;
  logic            scl_o;
  logic            scl_oe;
  logic            sda_o;
  logic            sda_oe;
  logic            m_oe;
  wire             scl = !scl_oe;
  wire             sda = !(sda_oe || m_oe);
  logic [7:0]      wq[$];
  logic [7:0]      rq[$];
  int              n_mismatch;
  int              tests_run;
  int              n_take;
  int              cyc;

  ee_host #(.QTR_CYC(4), .WR_CYC(2000)) dut (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .error(error),
    .protect_level(protect_level), .write_inhibit(write_inhibit),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));

  ee_eeprom_model mem_model (
    .scl(scl), .sda(sda), .write_inhibit(write_inhibit), .sda_oe(m_oe));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run(input ee_pkg::ee_op_t op, input logic [1:0] sp,
                     input logic [15:0] a, input logic [6:0] n);
    rq = {};
    n_take = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op, sp[1], sp[0], a, n};
    wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
    @(posedge clock);
    req_valid <= 1'b0;
    for (int t = 0; t < 20000 && done !== 1'b1; t++) begin
      @(posedge clock);
      if (wr_take === 1'b1) begin
        n_take++;
        if (n_take < wq.size()) wr_data <= wq[n_take];
      end
      if (rd_valid === 1'b1) rq.push_back(rd_data);
    end
    // A request that never finishes is a mismatch, not a silent pass
    chk(8'(done), 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_page;
    wq = {};
    for (int i = 0; i < 10; i++) wq.push_back(8'h80 + 8'(i));
    run(ee_pkg::OP_WRITE, 2'h1, 16'h013c, 7'h0a);
    chk(8'(error), 8'h00);
    chk(8'(n_take), 8'h0a);
    run(ee_pkg::OP_READ_RAND, 2'h1, 16'h0100, 7'h06);
    for (int i = 0; i < 6; i++) chk(rq[i], 8'h84 + 8'(i));
  endtask

  task automatic t_current;
    run(ee_pkg::OP_READ_CUR, 2'h1, 16'h0000, 7'h02);
    chk(rq[0], 8'h5c);
    chk(rq[1], 8'h5d);
  endtask

  task automatic t_wrap;
    run(ee_pkg::OP_READ_RAND, 2'h1, 16'hffff, 7'h02);
    chk(rq[0], 8'ha5);
    chk(rq[1], 8'h5a);
  endtask

  task automatic t_strap;
    for (int s = 0; s < 4; s++) begin
      if (s != 1) begin
        run(ee_pkg::OP_READ_CUR, 2'(s), 16'h0000, 7'h01);
        chk(8'(error), 8'h01);
      end
    end
  endtask

  task automatic t_protect;
    wq = {8'ha5};
    protect_level <= 1'b1;
    run(ee_pkg::OP_WRITE, 2'h1, 16'h0200, 7'h01);
    chk(8'(write_inhibit), 8'h01);
    run(ee_pkg::OP_READ_RAND, 2'h1, 16'h0200, 7'h01);
    chk(rq[0], 8'h5a);
    protect_level <= 1'b0;
    run(ee_pkg::OP_WRITE, 2'h1, 16'h0200, 7'h01);
    run(ee_pkg::OP_READ_RAND, 2'h1, 16'h0200, 7'h01);
    chk(rq[0], 8'ha5);
  endtask

  task automatic t_recover;
    run(ee_pkg::OP_RECOVER, 2'h0, 16'h0000, 7'h00);
    chk(8'(error), 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    wr_data = 8'h00;
    protect_level = 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_recover();
    t_page();
    t_current();
    t_wrap();
    t_strap();
    t_protect();
    give_verdict();
  end
endmodule

bind ee_host ee_host_monitor u_monitor (
  .clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
  .wr_take(wr_take), .rd_valid(rd_valid), .done(done),
  .protect_level(protect_level), .write_inhibit(write_inhibit),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
